// ### sample_sync_defines.svh
// register offsets, field positions, reset values and timing counts for the sample sync block
`ifndef SAMPLE_SYNC_DEFINES_SVH
`define SAMPLE_SYNC_DEFINES_SVH

// ********************************
// register byte offsets
// ********************************
`define OFS_SAMPLE_SYNC_CONTROL 8'h10
`define OFS_SEQUENCE_CONFIG 8'h14
`define OFS_SAMPLE_PERIOD 8'h18
`define OFS_SEQUENCE_STATUS 8'h1C

// ********************************
// field positions
// ********************************
`define PIN_FUNC_MSB 3
`define PIN_FUNC_LSB 0
`define CFG_LED_EN_LSB 0
`define CFG_MUX_EN_LSB 3
`define CFG_AMBIENT_EN_BIT 6
`define CFG_SHUTDOWN_BIT 7

// ********************************
// reset values
// ********************************
`define SAMPLE_SYNC_CONTROL_RST 8'h00
`define SEQUENCE_CONFIG_RST 8'h80
`define SAMPLE_PERIOD_RST 8'h20

// ********************************
// timing counts
// ********************************
`define EXPOSE_TICKS 4'h2

`endif

// ### sample_sync_pkg.sv
// types shared by the sample sync block
`default_nettype none

package sample_sync_pkg;

    // pin function codes handled here
    typedef enum logic [3:0] {
        PF_STANDALONE_INT = 4'h0,
        PF_STANDALONE_EXT = 4'h1,
        PF_SLAVE_INT = 4'h2,
        PF_SLAVE_EXT = 4'h3,
        PF_MASTER_INT = 4'h4,
        PF_MASTER_EXT = 4'h5
    } pin_func_e;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_EXPOSE = 3'h2,
        SEQ_STORE = 3'h4
    } seq_state_e;

    // slot index: 0..2 direct drivers, 3..5 muxed, 6 ambient, 7 none
    typedef logic [2:0] slot_t;

endpackage : sample_sync_pkg

`default_nettype wire

// ### sample_sync_pins.sv
// sample sync and auxiliary pin function logic with avalon-mm register slave
`default_nettype none

`include "sample_sync_defines.svh"

module sample_sync_pins
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // internal 32768 hz oscillator
    input wire logic osc_32k_in,
    // auxiliary pin a
    input wire logic aux_pin_a_in,
    output logic aux_pin_a_out,
    output logic aux_pin_a_oe,
    // auxiliary pin b
    input wire logic aux_pin_b_in,
    output logic aux_pin_b_out,
    output logic aux_pin_b_oe,
    // led drivers and fifo write
    output logic [2:0] led_drive,
    output logic fifo_wr,
    output logic [2:0] fifo_tag
);

    // ********************************
    // helper functions
    // ********************************
    function automatic sample_sync_pkg::slot_t first_slot(input sample_sync_pkg::slot_t from,
                                                          input logic [6:0] en);
        sample_sync_pkg::slot_t found;
        logic hit;
        found = 3'h7;
        hit = 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            if (!hit && (3'(i) >= from) && en[i])
            begin
                found = 3'(i);
                hit = 1'b1;
            end
        end
        return found;
    endfunction : first_slot

    function automatic logic is_muxed(input sample_sync_pkg::slot_t s);
        return (s >= 3'h3) && (s <= 3'h5);
    endfunction : is_muxed

    // ********************************
    // registers and state
    // ********************************
    logic [7:0] sync_control_reg;
    logic [7:0] seq_config_reg;
    logic [7:0] sample_period_reg;
    logic wait_reg;
    logic [31:0] readdata_reg;
    logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
    logic pa_s1_reg, pa_s2_reg, pa_s3_reg;
    logic pb_s1_reg, pb_s2_reg, pb_s3_reg;
    logic [7:0] period_cnt_reg;
    logic [7:0] period_cnt_next;
    logic [3:0] exp_cnt_reg;
    logic [3:0] exp_cnt_next;
    sample_sync_pkg::seq_state_e state_reg;
    sample_sync_pkg::seq_state_e state_next;
    sample_sync_pkg::slot_t slot_reg;
    sample_sync_pkg::slot_t slot_next;
    logic [2:0] led_reg;
    logic [2:0] led_next;
    logic fifo_wr_reg;
    logic [2:0] fifo_tag_reg;
    logic pa_out_reg, pa_oe_reg, pb_out_reg, pb_oe_reg;

    // ********************************
    // bus decode
    // ********************************
    wire logic req = avs_read | avs_write;
    wire logic accept = req & ~wait_reg;
    wire logic hit_ctrl = (avs_address == `OFS_SAMPLE_SYNC_CONTROL);
    wire logic hit_cfg = (avs_address == `OFS_SEQUENCE_CONFIG);
    wire logic hit_period = (avs_address == `OFS_SAMPLE_PERIOD);
    wire logic hit_status = (avs_address == `OFS_SEQUENCE_STATUS);
    wire logic wr_ctrl = accept & avs_write & hit_ctrl;
    wire logic wr_cfg = accept & avs_write & hit_cfg;
    wire logic wr_period = accept & avs_write & hit_period;
    wire logic [7:0] status_val = {state_reg == sample_sync_pkg::SEQ_IDLE, slot_reg, 1'b0, led_reg};
    wire logic [31:0] read_mux =
        hit_ctrl ? {24'h000000, sync_control_reg} :
        hit_cfg ? {24'h000000, seq_config_reg} :
        hit_period ? {24'h000000, sample_period_reg} :
        hit_status ? {24'h000000, status_val} : 32'h00000000;

    // ********************************
    // mode decode
    // ********************************
    wire logic [3:0] pin_func = sync_control_reg[`PIN_FUNC_MSB:`PIN_FUNC_LSB];
    wire logic func_known = (pin_func <= 4'h5);
    wire logic mode_mux_a = (pin_func == sample_sync_pkg::PF_STANDALONE_INT) |
                            (pin_func == sample_sync_pkg::PF_STANDALONE_EXT);
    wire logic mode_mux_b = (pin_func == sample_sync_pkg::PF_SLAVE_INT) |
                            (pin_func == sample_sync_pkg::PF_MASTER_INT);
    wire logic mode_slave = (pin_func == sample_sync_pkg::PF_SLAVE_INT) |
                            (pin_func == sample_sync_pkg::PF_SLAVE_EXT);
    wire logic mode_master = (pin_func == sample_sync_pkg::PF_MASTER_INT) |
                             (pin_func == sample_sync_pkg::PF_MASTER_EXT);
    wire logic ext_sample_clk = (pin_func == sample_sync_pkg::PF_STANDALONE_EXT) |
                                (pin_func == sample_sync_pkg::PF_MASTER_EXT);
    wire logic ext_expose_clk = ext_sample_clk | (pin_func == sample_sync_pkg::PF_SLAVE_EXT);

    // ********************************
    // tick sources
    // ********************************
    wire logic osc_rise = osc_s2_reg & ~osc_s3_reg;
    wire logic pa_rise = pa_s2_reg & ~pa_s3_reg;
    wire logic pb_rise = pb_s2_reg & ~pb_s3_reg;
    wire logic sample_tick = ext_sample_clk ? pb_rise : osc_rise;
    wire logic expose_tick = ext_expose_clk ? pb_rise : osc_rise;

    // ********************************
    // sequence configuration
    // ********************************
    wire logic [2:0] led_en = seq_config_reg[`CFG_LED_EN_LSB +: 3];
    wire logic [2:0] mux_en = seq_config_reg[`CFG_MUX_EN_LSB +: 3];
    wire logic amb_en = seq_config_reg[`CFG_AMBIENT_EN_BIT];
    wire logic running = ~seq_config_reg[`CFG_SHUTDOWN_BIT] & func_known;
    wire logic [6:0] slot_en = {amb_en, mux_en, led_en};
    wire logic any_mux = |mux_en;
    wire logic period_last = (period_cnt_reg + 8'h01 >= sample_period_reg);
    wire logic period_hit = sample_tick & period_last;
    wire logic start_sample = running & (mode_slave ? pa_rise : period_hit);
    wire logic expose_done = expose_tick & (exp_cnt_reg == `EXPOSE_TICKS - 4'h1);
    wire sample_sync_pkg::slot_t first_en = first_slot(3'h0, slot_en);
    wire sample_sync_pkg::slot_t after_en = first_slot(slot_reg + 3'h1, slot_en);

    // ********************************
    // sequencer next state
    // ********************************
    always_comb
    begin
        state_next = state_reg;
        slot_next = slot_reg;
        exp_cnt_next = exp_cnt_reg;
        case (state_reg)
            sample_sync_pkg::SEQ_IDLE:
            begin
                if (start_sample && first_en != 3'h7)
                begin
                    state_next = sample_sync_pkg::SEQ_EXPOSE;
                    slot_next = first_en;
                    exp_cnt_next = 4'h0;
                end
            end
            sample_sync_pkg::SEQ_EXPOSE:
            begin
                if (!running)
                begin
                    state_next = sample_sync_pkg::SEQ_IDLE;
                end
                else if (expose_done)
                begin
                    state_next = sample_sync_pkg::SEQ_STORE;
                end
                else if (expose_tick)
                begin
                    exp_cnt_next = exp_cnt_reg + 4'h1;
                end
            end
            sample_sync_pkg::SEQ_STORE:
            begin
                exp_cnt_next = 4'h0;
                if (after_en == 3'h7 || !running)
                begin
                    state_next = sample_sync_pkg::SEQ_IDLE;
                end
                else
                begin
                    state_next = sample_sync_pkg::SEQ_EXPOSE;
                    slot_next = after_en;
                end
            end
            default:
            begin
                state_next = sample_sync_pkg::SEQ_IDLE;
            end
        endcase
    end

    // ********************************
    // output next values
    // ********************************
    wire logic exposing_next = (state_next == sample_sync_pkg::SEQ_EXPOSE);
    wire logic muxed_next = exposing_next & is_muxed(slot_next);
    wire logic busy_next = (state_next != sample_sync_pkg::SEQ_IDLE);
    wire logic [2:0] drv_index = is_muxed(slot_next) ? slot_next - 3'h3 : slot_next;
    assign led_next = (exposing_next && slot_next != 3'h6) ? (3'h1 << drv_index) : 3'h0;
    wire logic pa_oe_next = (mode_mux_a & any_mux) | mode_master;
    wire logic pa_out_next = mode_master ? busy_next : ~muxed_next;
    wire logic pb_oe_next = mode_mux_b & any_mux;
    wire logic pb_out_next = ~muxed_next;
    assign period_cnt_next = (!running || mode_slave || period_hit) ? 8'h00 :
                             sample_tick ? period_cnt_reg + 8'h01 : period_cnt_reg;

    // ********************************
    // bus slave
    // ********************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wait_reg <= 1'b1;
            readdata_reg <= 32'h00000000;
        end
        else
        begin
            wait_reg <= ~(req & wait_reg);
            readdata_reg <= read_mux;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sync_control_reg <= `SAMPLE_SYNC_CONTROL_RST;
            seq_config_reg <= `SEQUENCE_CONFIG_RST;
            sample_period_reg <= `SAMPLE_PERIOD_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                sync_control_reg <= avs_writedata[7:0];
            end
            if (wr_cfg)
            begin
                seq_config_reg <= avs_writedata[7:0];
            end
            if (wr_period)
            begin
                sample_period_reg <= avs_writedata[7:0];
            end
        end
    end

    // ********************************
    // synchronisers
    // ********************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            {osc_s1_reg, osc_s2_reg, osc_s3_reg} <= 3'h0;
            // pins idle high behind pull-ups, no false edge
            {pa_s1_reg, pa_s2_reg, pa_s3_reg} <= 3'h7;
            {pb_s1_reg, pb_s2_reg, pb_s3_reg} <= 3'h7;
        end
        else
        begin
            {osc_s1_reg, osc_s2_reg, osc_s3_reg} <= {osc_32k_in, osc_s1_reg, osc_s2_reg};
            {pa_s1_reg, pa_s2_reg, pa_s3_reg} <= {aux_pin_a_in, pa_s1_reg, pa_s2_reg};
            {pb_s1_reg, pb_s2_reg, pb_s3_reg} <= {aux_pin_b_in, pb_s1_reg, pb_s2_reg};
        end
    end

    // ********************************
    // sequencer and pins
    // ********************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= sample_sync_pkg::SEQ_IDLE;
            slot_reg <= 3'h0;
            exp_cnt_reg <= 4'h0;
            period_cnt_reg <= 8'h00;
            led_reg <= 3'h0;
            fifo_wr_reg <= 1'b0;
            fifo_tag_reg <= 3'h0;
            pa_out_reg <= 1'b0;
            pa_oe_reg <= 1'b0;
            pb_out_reg <= 1'b0;
            pb_oe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            exp_cnt_reg <= exp_cnt_next;
            period_cnt_reg <= period_cnt_next;
            led_reg <= led_next;
            fifo_wr_reg <= (state_reg == sample_sync_pkg::SEQ_EXPOSE) & expose_done & running;
            fifo_tag_reg <= slot_reg;
            pa_out_reg <= pa_out_next;
            pa_oe_reg <= pa_oe_next;
            pb_out_reg <= pb_out_next;
            pb_oe_reg <= pb_oe_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = readdata_reg;
    assign led_drive = led_reg;
    assign fifo_wr = fifo_wr_reg;
    assign fifo_tag = fifo_tag_reg;
    assign aux_pin_a_out = pa_out_reg;
    assign aux_pin_a_oe = pa_oe_reg;
    assign aux_pin_b_out = pb_out_reg;
    assign aux_pin_b_oe = pb_oe_reg;

endmodule : sample_sync_pins

`default_nettype wire

// ### sample_sync_props.sv
// concurrent checks on the sample sync block ports
`default_nettype none

module sample_sync_props
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins
    input wire logic osc_32k_in,
    input wire logic aux_pin_a_in,
    input wire logic aux_pin_a_out,
    input wire logic aux_pin_a_oe,
    input wire logic aux_pin_b_in,
    input wire logic aux_pin_b_out,
    input wire logic aux_pin_b_oe,
    // sequencer
    input wire logic [2:0] led_drive,
    input wire logic fifo_wr,
    input wire logic [2:0] fifo_tag
);
    // ****
    // register shadow
    // ****
    logic [7:0] ctl_reg;
    logic [7:0] cfg_reg;
    logic [1:0] age_reg;
    wire logic hit = avs_write && !avs_waitrequest;
    wire logic ctl_hit = hit && (avs_address == 8'h10);
    wire logic cfg_hit = hit && (avs_address == 8'h14);
    wire logic quiet = (age_reg == 2'h3);
    wire logic mux_any = |cfg_reg[5:3];
    wire logic [3:0] pf = ctl_reg[3:0];
    wire logic led_on = (led_drive != 3'h0);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctl_reg <= 8'h00;
            cfg_reg <= 8'h80;
            age_reg <= 2'h0;
        end
        else
        begin
            ctl_reg <= ctl_hit ? avs_writedata[7:0] : ctl_reg;
            cfg_reg <= cfg_hit ? avs_writedata[7:0] : cfg_reg;
            age_reg <= (ctl_hit || cfg_hit) ? 2'h0 : (quiet ? age_reg : age_reg + 2'h1);
        end
    end

    // ****
    // properties
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    chk_read_ctl: assert property (avs_read && !avs_waitrequest && avs_address == 8'h10 |-> avs_readdata == {24'h0, ctl_reg}) else $error("ctl read");
    chk_led_onehot: assert property ($onehot0(led_drive)) else $error("led select");
    chk_pin_a_mux: assert property (quiet && pf[3:1] == 3'h0 && aux_pin_a_oe && !aux_pin_a_out |-> led_on) else $error("pin a low");
    chk_pin_a_tri: assert property (quiet && pf[3:1] == 3'h0 && !mux_any |-> !aux_pin_a_oe) else $error("pin a driven");
    chk_pin_b_input: assert property (quiet && (pf[3:1] == 3'h0 || pf == 4'h3 || pf == 4'h5) |-> !aux_pin_b_oe) else $error("pin b driven");
    chk_slave_input: assert property (quiet && pf[3:1] == 3'h1 |-> !aux_pin_a_oe) else $error("slave pin a driven");
    chk_pin_b_mux: assert property (quiet && (pf == 4'h2 || pf == 4'h4) && aux_pin_b_oe && !aux_pin_b_out |-> led_on) else $error("pin b low");
    chk_pin_b_tri: assert property (quiet && (pf == 4'h2 || pf == 4'h4) && !mux_any |-> !aux_pin_b_oe) else $error("pin b driven");
    chk_master_out: assert property (quiet && pf[3:1] == 3'h2 && led_on |-> aux_pin_a_oe && aux_pin_a_out) else $error("master out");
    chk_wr_pulse: assert property (fifo_wr |=> !fifo_wr) else $error("long write");
    chk_high_idle: assert property (quiet && pf > 4'h5 |-> !aux_pin_a_oe && !aux_pin_b_oe && !led_on && !fifo_wr) else $error("busy");

    cov_master: cover property (pf == 4'h4 && aux_pin_a_oe && aux_pin_a_out);
    cov_mux_b: cover property (aux_pin_b_oe && !aux_pin_b_out);
    cov_ambient: cover property (fifo_wr && fifo_tag == 3'h6);
    cov_trigger: cover property (pf[3:1] == 3'h1 && $rose(aux_pin_a_in));
endmodule : sample_sync_props

bind sample_sync_pins sample_sync_props sample_sync_props_inst (.clk_sys, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .osc_32k_in, .aux_pin_a_in, .aux_pin_a_out,
    .aux_pin_a_oe, .aux_pin_b_in, .aux_pin_b_out, .aux_pin_b_oe, .led_drive, .fifo_wr, .fifo_tag);

`default_nettype wire

// ### sync_far_side.sv
// far side model: clock source, trigger source, pull-ups
`default_nettype none

module sync_far_side
(
    // device pins
    input wire logic aux_pin_a_out,
    input wire logic aux_pin_a_oe,
    input wire logic aux_pin_b_out,
    input wire logic aux_pin_b_oe,
    output logic aux_pin_a_in,
    output logic aux_pin_b_in,
    // controls
    input wire logic clk_run,
    input wire logic trig_on,
    input wire logic trig_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ext_clk = 1'b0;

    // clock runs only while enabled
    always
    begin
        #400;
        ext_clk = clk_run ? ~ext_clk : 1'b0;
    end

    // pulled-up wires, device drive wins
    assign aux_pin_a_in = aux_pin_a_oe ? aux_pin_a_out : (trig_on ? trig_level : 1'b1);
    assign aux_pin_b_in = aux_pin_b_oe ? aux_pin_b_out : (clk_run ? ext_clk : 1'b1);
endmodule : sync_far_side

`default_nettype wire

// ### testbench.sv
// self-checking bench for the sample sync pin functions
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic osc_32k_in = 1'b0;
    logic aux_pin_a_in, aux_pin_a_out, aux_pin_a_oe;
    logic aux_pin_b_in, aux_pin_b_out, aux_pin_b_oe;
    logic [2:0] led_drive;
    logic fifo_wr;
    logic [2:0] fifo_tag;
    logic clk_run = 1'b0;
    logic trig_on = 1'b0;
    logic trig_level = 1'b0;
    logic [31:0] rd;
    int bad_count = 0;
    int compares = 0;

    always #50 clk_sys = ~clk_sys;
    always #15259 osc_32k_in = ~osc_32k_in;

    sample_sync_pins sample_sync_pins_inst (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .osc_32k_in, .aux_pin_a_in, .aux_pin_a_out,
        .aux_pin_a_oe, .aux_pin_b_in, .aux_pin_b_out, .aux_pin_b_oe, .led_drive, .fifo_wr, .fifo_tag);
    sync_far_side sync_far_side_inst (.aux_pin_a_out, .aux_pin_a_oe, .aux_pin_b_out, .aux_pin_b_oe,
        .aux_pin_a_in, .aux_pin_b_in, .clk_run, .trig_on, .trig_level);

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : check

    function automatic logic [3:0] pin_exp(input logic [3:0] code, input logic [7:0] cfg, input logic [2:0] slot);
        logic mux;
        logic low;
        mux = |cfg[5:3];
        low = (slot >= 3'h3) && (slot <= 3'h5);
        case (code)
            4'h0, 4'h1: return {mux, mux & !low, 2'h0};
            4'h2: return {2'h0, mux, mux & !low};
            4'h4: return {2'h3, mux, mux & !low};
            4'h5: return 4'hC;
            default: return 4'h0;
        endcase
    endfunction : pin_exp

    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            bad_count++;
            end_of_test();
        end
    endtask : bus

    task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask : rchk

    task automatic run(input logic [3:0] code, input logic [7:0] cfg, input logic trig, input logic ext);
        logic [2:0] exp[$];
        int n;
        int seen;
        int gap;
        logic [3:0] pins;
        exp = {};
        for (int i = 0; i < 7; i++)
            if (cfg[i] && code < 4'h6)
                exp.push_back(3'(i));
        bus(1'b1, 8'h14, 32'h0000_0080);
        bus(1'b1, 8'h10, {28'h0, code});
        rchk(8'h10, {28'h0, code});
        clk_run <= ext;
        bus(1'b1, 8'h14, {24'h0, cfg});
        if (trig)
        begin
            repeat (400) @(posedge clk_sys);
            check({29'h0, led_drive}, 32'h0);
            trig_on <= 1'b1;
            repeat (6) @(posedge clk_sys);
            trig_level <= 1'b1;
            repeat (6) @(posedge clk_sys);
            trig_on <= 1'b0;
            trig_level <= 1'b0;
        end
        seen = 0;
        n = 0;
        gap = 0;
        pins = 4'h0;
        while (n < 20000 && (seen < exp.size() || (exp.size() == 0 && n < 3000)))
        begin
            @(posedge clk_sys);
            n++;
            gap++;
            if (fifo_wr === 1'b1)
            begin
                if (seen < exp.size())
                begin
                    check({29'h0, fifo_tag}, {29'h0, exp[seen]});
                    check({28'h0, pins}, {28'h0, pin_exp(code, cfg, exp[seen])});
                end
                if (ext)
                    check({31'h0, (gap <= 100)}, 32'h1);
                gap = 0;
                seen++;
            end
            pins = {aux_pin_a_oe, aux_pin_a_oe & aux_pin_a_out, aux_pin_b_oe, aux_pin_b_oe & aux_pin_b_out};
        end
        check(32'(seen), 32'(exp.size()));
        if (seen < exp.size())
            end_of_test();
        bus(1'b1, 8'h14, 32'h0000_0080);
        clk_run <= 1'b0;
        $display("test done: mode %h config %h", code, cfg);
    endtask : run

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rchk(8'h10, 32'h0000_0000);
        rchk(8'h14, 32'h0000_0080);
        rchk(8'h18, 32'h0000_0020);
        rchk(8'h04, 32'h0000_0000);
        bus(1'b1, 8'h18, 32'h0000_0001);
        rchk(8'h18, 32'h0000_0001);
        $display("test done: registers");
        run(4'h0, 8'h4F, 1'b0, 1'b0);
        run(4'h0, 8'h47, 1'b0, 1'b0);
        run(4'h1, 8'h79, 1'b0, 1'b1);
        run(4'h2, 8'h23, 1'b1, 1'b0);
        run(4'h2, 8'h41, 1'b1, 1'b0);
        run(4'h3, 8'h43, 1'b1, 1'b1);
        run(4'h4, 8'h51, 1'b0, 1'b0);
        run(4'h4, 8'h41, 1'b0, 1'b0);
        run(4'h5, 8'h44, 1'b0, 1'b1);
        run(4'h6, 8'h41, 1'b0, 1'b0);
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
